// [cod_pkg.sv]
// Package of constants and types for the CPU operand and control-flow decoder
// *****************************************************************************
// What this block does
// - A bit-number operand is a three-bit field picking one of eight bit positions 0 to 7.
// - A direct-address operand is a full 16-bit program address from 0000 to FFFF.
// - An extended-register operand is a 12-bit register file address from 000 to FFF.
// - An immediate operand is one literal byte from the instruction stream, 00 to FF.
// - An indirect register-pair operand always points at an even register address.
// - A working-pair operand picks one of eight even pairs among sixteen working registers.
// - A relative operand is a signed byte added to the next instruction's address.
// - A polarity operand is one bit saying whether the bit value is zero or one.
// - Decrement-and-branch decrements the working register named in the upper nibble and
//        branches by the displacement when the result is nonzero.
// - Interrupt return pops flags, then the two-byte program counter, then sets interrupt enable.
// - The conditional jump loads its destination only when the upper-nibble condition is true.
// *****************************************************************************
package cod_pkg;

   // *************************************************************************
   // Operand field widths and limits
   // *************************************************************************
   localparam int BIT_W      = 3;
   localparam int DIRECT_W   = 16;
   localparam int EXT_REG_W  = 12;
   localparam int IMM_W      = 8;
   localparam int REG_W      = 8;
   localparam int WREG_W     = 4;
   localparam logic [7:0] EVEN_MASK = 8'hFE;

   // *************************************************************************
   // Opcode encodings
   // *************************************************************************
   localparam logic [3:0] LO_DEC_BRANCH  = 4'hA;
   localparam logic [3:0] LO_JPCC        = 4'hD;
   localparam logic [7:0] OP_INT_RETURN  = 8'hBF;
   localparam logic [7:0] OP_JUMP_DIRECT = 8'h8D;
   localparam logic [7:0] OP_BIT     = 8'hE2;
   localparam logic [7:0] OP_BTJ_R   = 8'hF6;
   localparam logic [7:0] OP_BTJ_IR  = 8'hF7;
   localparam logic [7:0] OP_DECW    = 8'h80;
   localparam logic [7:0] OP_LDE     = 8'hC2;
   localparam logic [7:0] OP_ADDX_IMM = 8'h09;
   localparam logic [7:0] OP_ADD_IM  = 8'h06;
   localparam logic [7:0] OP_ESC2    = 8'h1F;

   // Global interrupt enable position in the interrupt control register
   localparam int IRQ_EN_BIT = 7;
   // Stack depth restored by an interrupt return: flags byte, then two PC bytes
   localparam logic [15:0] SP_FLAGS_STEP = 16'h0001;
   localparam logic [15:0] SP_PC_STEP    = 16'h0002;

   // Condition codes
   localparam logic [3:0] CC_F   = 4'h0;
   localparam logic [3:0] CC_LT  = 4'h1;
   localparam logic [3:0] CC_LE  = 4'h2;
   localparam logic [3:0] CC_ULE = 4'h3;
   localparam logic [3:0] CC_OV  = 4'h4;
   localparam logic [3:0] CC_MI  = 4'h5;
   localparam logic [3:0] CC_Z   = 4'h6;
   localparam logic [3:0] CC_C   = 4'h7;
   localparam logic [3:0] CC_T   = 4'h8;
   localparam logic [3:0] CC_GE  = 4'h9;
   localparam logic [3:0] CC_GT  = 4'hA;
   localparam logic [3:0] CC_UGT = 4'hB;
   localparam logic [3:0] CC_NOV = 4'hC;
   localparam logic [3:0] CC_PL  = 4'hD;
   localparam logic [3:0] CC_NZ  = 4'hE;
   localparam logic [3:0] CC_NC  = 4'hF;

   // Flag positions in the flags byte: C Z S V D H
   localparam int FL_C = 7;
   localparam int FL_Z = 6;
   localparam int FL_S = 5;
   localparam int FL_V = 4;

   // Decoded operation classes
   typedef enum logic [2:0] {
      COD_OP_NONE,
      COD_OP_DEC_BRANCH,
      COD_OP_JPCC,
      COD_OP_JUMP,
      COD_OP_INT_RET,
      COD_OP_OTHER
   } cod_op_e;

   // Interrupt-return sequencing states
   typedef enum logic [2:0] {
      COD_IR_IDLE,
      COD_IR_FLAGS,
      COD_IR_PCHI,
      COD_IR_PCLO,
      COD_IR_DONE
   } cod_ir_e;

endpackage

// [cod_legal.sv]
// Opcode legality table for the first opcode map
`timescale 1ns/1ps
module cod_legal (
   input  wire logic [7:0] opcode_in,
   output logic            legal_out
);

   logic [3:0] hi;
   logic [3:0] lo;

   assign hi = opcode_in[7:4];
   assign lo = opcode_in[3:0];

   // *************************************************************************
   // Map by column; holes in the map are illegal
   // *************************************************************************
   always_comb begin
      unique case (lo)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h7: legal_out = 1'b1;
         4'h4: legal_out = 1'b1;
         4'h5: legal_out = 1'b1;
         4'h6: legal_out = (hi != 4'hC);
         4'h8: legal_out = (hi != 4'hF);
         4'h9: legal_out = (hi != 4'hC) && (hi != 4'hD) && (hi != 4'hF);
         4'hA, 4'hB, 4'hC, 4'hD, 4'hE: legal_out = 1'b1;
         4'hF: legal_out = (hi != 4'h2) && (hi != 4'h3) && (hi != 4'h4);
      endcase
   end

endmodule // cod_legal

// [cod_decode.sv]
// Operand and control-flow decoder of the CPU core
`timescale 1ns/1ps
module cod_decode (
   input  wire logic        CLK_SYS_IN,
   input  wire logic        RST_N_IN,
   input  wire logic        INSTR_VALID_IN,
   input  wire logic [7:0]  OPCODE_IN,
   input  wire logic [7:0]  OPND1_IN,
   input  wire logic [7:0]  OPND2_IN,
   input  wire logic [15:0] NEXT_PC_IN,
   input  wire logic [7:0]  WREG_VALUE_IN,
   input  wire logic [7:0]  FLAGS_IN,
   input  wire logic [7:0]  STACK_DATA_IN,
   input  wire logic [15:0] SP_IN,
   output logic             BUSY_OUT,
   output logic             ILLEGAL_OUT,
   output logic [2:0]       BIT_SEL_OUT,
   output logic             POLARITY_OUT,
   output logic [15:0]      DIRECT_ADDR_OUT,
   output logic [11:0]      EXT_REG_OUT,
   output logic [7:0]       IMM_DATA_OUT,
   output logic [7:0]       REG_PAIR_OUT,
   output logic [3:0]       WORK_PAIR_OUT,
   output logic [15:0]      REL_TARGET_OUT,
   output logic             WREG_WE_OUT,
   output logic [3:0]       WREG_SEL_OUT,
   output logic [7:0]       WREG_DATA_OUT,
   output logic             PC_LOAD_OUT,
   output logic [15:0]      PC_VALUE_OUT,
   output logic             STACK_RD_OUT,
   output logic [15:0]      STACK_ADDR_OUT,
   output logic             FLAGS_WE_OUT,
   output logic [7:0]       FLAGS_DATA_OUT,
   output logic             SP_WE_OUT,
   output logic [15:0]      SP_DATA_OUT,
   output logic             IRQ_EN_SET_OUT
);

   // *************************************************************************
   // Declarations
   // *************************************************************************
   logic              legal;
   logic [3:0]        hi;
   logic [3:0]        lo;
   logic [7:0]        dec_val;
   logic              cc_true;
   logic              take;
   cod_pkg::cod_ir_e  ir_q;
   logic [15:0]       sp_q;
   logic [7:0]        pc_hi_q;

   assign hi = OPCODE_IN[7:4];
   assign lo = OPCODE_IN[3:0];
   assign take = INSTR_VALID_IN && (ir_q == cod_pkg::COD_IR_IDLE);
   assign BUSY_OUT = (ir_q != cod_pkg::COD_IR_IDLE);

   cod_legal u_legal (
      .opcode_in (OPCODE_IN),
      .legal_out (legal)
   );

   // *************************************************************************
   // Condition evaluation
   // *************************************************************************
   always_comb begin
      unique case (hi)
         cod_pkg::CC_F:   cc_true = 1'b0;
         cod_pkg::CC_LT:  cc_true = FLAGS_IN[cod_pkg::FL_S] ^ FLAGS_IN[cod_pkg::FL_V];
         cod_pkg::CC_LE:  cc_true = FLAGS_IN[cod_pkg::FL_Z] |
                                    (FLAGS_IN[cod_pkg::FL_S] ^ FLAGS_IN[cod_pkg::FL_V]);
         cod_pkg::CC_ULE: cc_true = FLAGS_IN[cod_pkg::FL_C] | FLAGS_IN[cod_pkg::FL_Z];
         cod_pkg::CC_OV:  cc_true = FLAGS_IN[cod_pkg::FL_V];
         cod_pkg::CC_MI:  cc_true = FLAGS_IN[cod_pkg::FL_S];
         cod_pkg::CC_Z:   cc_true = FLAGS_IN[cod_pkg::FL_Z];
         cod_pkg::CC_C:   cc_true = FLAGS_IN[cod_pkg::FL_C];
         cod_pkg::CC_T:   cc_true = 1'b1;
         cod_pkg::CC_GE:  cc_true = ~(FLAGS_IN[cod_pkg::FL_S] ^ FLAGS_IN[cod_pkg::FL_V]);
         cod_pkg::CC_GT:  cc_true = ~(FLAGS_IN[cod_pkg::FL_Z] |
                                      (FLAGS_IN[cod_pkg::FL_S] ^ FLAGS_IN[cod_pkg::FL_V]));
         cod_pkg::CC_UGT: cc_true = ~(FLAGS_IN[cod_pkg::FL_C] | FLAGS_IN[cod_pkg::FL_Z]);
         cod_pkg::CC_NOV: cc_true = ~FLAGS_IN[cod_pkg::FL_V];
         cod_pkg::CC_PL:  cc_true = ~FLAGS_IN[cod_pkg::FL_S];
         cod_pkg::CC_NZ:  cc_true = ~FLAGS_IN[cod_pkg::FL_Z];
         cod_pkg::CC_NC:  cc_true = ~FLAGS_IN[cod_pkg::FL_C];
      endcase
   end

   assign dec_val = WREG_VALUE_IN - 8'h01;

   // *************************************************************************
   // Operand fields, registered per accepted instruction
   // *************************************************************************
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_N_IN) begin
         BIT_SEL_OUT     <= 3'h0;
         POLARITY_OUT    <= 1'b0;
         DIRECT_ADDR_OUT <= 16'h0000;
         EXT_REG_OUT     <= 12'h000;
         IMM_DATA_OUT    <= 8'h00;
         REG_PAIR_OUT    <= 8'h00;
         WORK_PAIR_OUT   <= 4'h0;
         REL_TARGET_OUT  <= 16'h0000;
         ILLEGAL_OUT     <= 1'b0;
      end else if (take) begin
         // Bit-test forms carry polarity in bit 7 and bit number in bits 6:4
         BIT_SEL_OUT     <= OPND1_IN[6:4];
         POLARITY_OUT    <= OPND1_IN[7];
         DIRECT_ADDR_OUT <= {OPND1_IN, OPND2_IN};
         EXT_REG_OUT     <= {OPND1_IN[3:0], OPND2_IN};
         IMM_DATA_OUT    <= OPND2_IN;
         // Low bit forced clear so a pair can never straddle an odd boundary
         REG_PAIR_OUT    <= OPND1_IN & cod_pkg::EVEN_MASK;
         WORK_PAIR_OUT   <= {OPND1_IN[7:5], 1'b0};
         REL_TARGET_OUT  <= NEXT_PC_IN + {{8{OPND1_IN[7]}}, OPND1_IN};
         ILLEGAL_OUT     <= !legal;
      end else begin
         ILLEGAL_OUT     <= 1'b0;
      end
   end

   // *************************************************************************
   // Decrement-and-branch and conditional jump
   // *************************************************************************
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_N_IN) begin
         WREG_WE_OUT   <= 1'b0;
         WREG_SEL_OUT  <= 4'h0;
         WREG_DATA_OUT <= 8'h00;
      end else begin
         WREG_WE_OUT   <= take && legal && (lo == cod_pkg::LO_DEC_BRANCH);
         WREG_SEL_OUT  <= hi;
         WREG_DATA_OUT <= dec_val;
      end
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_N_IN) begin
         PC_LOAD_OUT  <= 1'b0;
         PC_VALUE_OUT <= 16'h0000;
      end else if (take && (lo == cod_pkg::LO_DEC_BRANCH)) begin
         PC_LOAD_OUT  <= (dec_val != 8'h00);
         PC_VALUE_OUT <= NEXT_PC_IN + {{8{OPND1_IN[7]}}, OPND1_IN};
      end else if (take && (lo == cod_pkg::LO_JPCC)) begin
         PC_LOAD_OUT  <= cc_true;
         PC_VALUE_OUT <= {OPND1_IN, OPND2_IN};
      end else if (take && (OPCODE_IN == cod_pkg::OP_JUMP_DIRECT)) begin
         PC_LOAD_OUT  <= 1'b1;
         PC_VALUE_OUT <= {OPND1_IN, OPND2_IN};
      end else if (ir_q == cod_pkg::COD_IR_PCLO) begin
         PC_LOAD_OUT  <= 1'b1;
         PC_VALUE_OUT <= {pc_hi_q, STACK_DATA_IN};
      end else begin
         PC_LOAD_OUT  <= 1'b0;
      end
   end

   // *************************************************************************
   // Interrupt return sequence: flags, PC high, PC low, enable
   // *************************************************************************
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_N_IN) begin
         ir_q <= cod_pkg::COD_IR_IDLE;
      end else begin
         unique case (ir_q)
            cod_pkg::COD_IR_IDLE:
               if (take && (OPCODE_IN == cod_pkg::OP_INT_RETURN)) begin
                  ir_q <= cod_pkg::COD_IR_FLAGS;
               end
            cod_pkg::COD_IR_FLAGS: ir_q <= cod_pkg::COD_IR_PCHI;
            cod_pkg::COD_IR_PCHI:  ir_q <= cod_pkg::COD_IR_PCLO;
            cod_pkg::COD_IR_PCLO:  ir_q <= cod_pkg::COD_IR_DONE;
            cod_pkg::COD_IR_DONE:  ir_q <= cod_pkg::COD_IR_IDLE;
            default:               ir_q <= cod_pkg::COD_IR_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_N_IN) begin
         sp_q    <= 16'h0000;
         pc_hi_q <= 8'h00;
      end else if (take && (OPCODE_IN == cod_pkg::OP_INT_RETURN)) begin
         sp_q    <= SP_IN;
      end else if (ir_q == cod_pkg::COD_IR_PCHI) begin
         pc_hi_q <= STACK_DATA_IN;
      end
   end

   // Stack read address walks the popped bytes; data returns combinationally
   always_comb begin
      STACK_RD_OUT   = 1'b0;
      STACK_ADDR_OUT = sp_q;
      unique case (ir_q)
         cod_pkg::COD_IR_FLAGS: STACK_RD_OUT = 1'b1;
         cod_pkg::COD_IR_PCHI: begin
            STACK_RD_OUT   = 1'b1;
            STACK_ADDR_OUT = sp_q + cod_pkg::SP_FLAGS_STEP;
         end
         cod_pkg::COD_IR_PCLO: begin
            STACK_RD_OUT   = 1'b1;
            STACK_ADDR_OUT = sp_q + cod_pkg::SP_FLAGS_STEP + 16'h0001;
         end
         default: STACK_RD_OUT = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (!RST_N_IN) begin
         FLAGS_WE_OUT   <= 1'b0;
         FLAGS_DATA_OUT <= 8'h00;
         SP_WE_OUT      <= 1'b0;
         SP_DATA_OUT    <= 16'h0000;
         IRQ_EN_SET_OUT <= 1'b0;
      end else begin
         FLAGS_WE_OUT   <= (ir_q == cod_pkg::COD_IR_FLAGS);
         if (ir_q == cod_pkg::COD_IR_FLAGS) begin
            FLAGS_DATA_OUT <= STACK_DATA_IN;
         end
         SP_WE_OUT      <= (ir_q == cod_pkg::COD_IR_PCLO);
         SP_DATA_OUT    <= sp_q + cod_pkg::SP_FLAGS_STEP + cod_pkg::SP_PC_STEP;
         // Enable comes last so no interrupt can nest before the PC is back
         IRQ_EN_SET_OUT <= (ir_q == cod_pkg::COD_IR_DONE);
      end
   end

   // *************************************************************************
   // Assertions
   // *************************************************************************
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RST_N_IN);

   bit_field_a: assert property (take |=> BIT_SEL_OUT == $past(OPND1_IN[6:4]))
      else $error("bit select not taken from operand");
   direct_addr_a: assert property (take |=> DIRECT_ADDR_OUT == $past({OPND1_IN, OPND2_IN}))
      else $error("direct address wrong");
   ext_reg_a: assert property (take |=> EXT_REG_OUT == $past({OPND1_IN[3:0], OPND2_IN}))
      else $error("extended register wrong");
   imm_data_a: assert property (take |=> IMM_DATA_OUT == $past(OPND2_IN))
      else $error("immediate wrong");
   pair_even_a: assert property (REG_PAIR_OUT[0] == 1'b0)
      else $error("register pair odd");
   work_even_a: assert property (WORK_PAIR_OUT[0] == 1'b0)
      else $error("working pair odd");
   rel_target_a: assert property (take |=> REL_TARGET_OUT ==
         $past(NEXT_PC_IN + {{8{OPND1_IN[7]}}, OPND1_IN}))
      else $error("relative target wrong");
   polarity_a: assert property (take |=> POLARITY_OUT == $past(OPND1_IN[7]))
      else $error("polarity wrong");
   dec_branch_a: assert property (take && lo == cod_pkg::LO_DEC_BRANCH |=>
         WREG_WE_OUT && PC_LOAD_OUT == ($past(WREG_VALUE_IN) != 8'h01))
      else $error("decrement branch wrong");
   ret_order_a: assert property (take && OPCODE_IN == cod_pkg::OP_INT_RETURN |=>
         ##1 FLAGS_WE_OUT ##2 PC_LOAD_OUT && SP_WE_OUT ##1 IRQ_EN_SET_OUT)
      else $error("interrupt return order wrong");
   jpcc_cond_a: assert property (take && lo == cod_pkg::LO_JPCC |=>
         PC_LOAD_OUT == $past(cc_true))
      else $error("conditional jump wrong");
   illegal_a: assert property (take |=> ILLEGAL_OUT == $past(!legal))
      else $error("illegal flag wrong");

   dec_branch_c: cover property (take && lo == cod_pkg::LO_DEC_BRANCH && WREG_VALUE_IN != 8'h01);
   ret_done_c: cover property (IRQ_EN_SET_OUT);
   jpcc_c: cover property (take && lo == cod_pkg::LO_JPCC && !cc_true);
   illegal_c: cover property (ILLEGAL_OUT);

endmodule // cod_decode

// [cod_decode_tb.sv]
// Self-checking testbench of the CPU operand and control-flow decoder
`timescale 1ns/1ps
module cod_decode_tb;
   // ************************************************************************
   // Stimulus and observed signals
   // ************************************************************************
   logic        clk_sys, rst_n, valid;
   logic [7:0]  opcode, opnd1, opnd2, wreg_value, flags, stack_data;
   logic [15:0] next_pc, sp;
   logic        busy, illegal, polarity, wreg_we, pc_load, stack_rd, flags_we, sp_we, irq_set;
   logic [2:0]  bit_sel;
   logic [15:0] direct_addr, rel_target, pc_value, stack_addr, sp_data;
   logic [11:0] ext_reg;
   logic [7:0]  imm_data, reg_pair, wreg_data, flags_data;
   logic [3:0]  work_pair, wreg_sel;
   int          n_mismatch = 0;
   int          n_checks   = 0;
   int          cycles     = 0;

   cod_decode DUT (.CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .INSTR_VALID_IN(valid),
      .OPCODE_IN(opcode), .OPND1_IN(opnd1), .OPND2_IN(opnd2), .NEXT_PC_IN(next_pc),
      .WREG_VALUE_IN(wreg_value), .FLAGS_IN(flags), .STACK_DATA_IN(stack_data), .SP_IN(sp),
      .BUSY_OUT(busy), .ILLEGAL_OUT(illegal), .BIT_SEL_OUT(bit_sel), .POLARITY_OUT(polarity),
      .DIRECT_ADDR_OUT(direct_addr), .EXT_REG_OUT(ext_reg), .IMM_DATA_OUT(imm_data),
      .REG_PAIR_OUT(reg_pair), .WORK_PAIR_OUT(work_pair), .REL_TARGET_OUT(rel_target),
      .WREG_WE_OUT(wreg_we), .WREG_SEL_OUT(wreg_sel), .WREG_DATA_OUT(wreg_data),
      .PC_LOAD_OUT(pc_load), .PC_VALUE_OUT(pc_value), .STACK_RD_OUT(stack_rd),
      .STACK_ADDR_OUT(stack_addr), .FLAGS_WE_OUT(flags_we), .FLAGS_DATA_OUT(flags_data),
      .SP_WE_OUT(sp_we), .SP_DATA_OUT(sp_data), .IRQ_EN_SET_OUT(irq_set));

   // Stack memory answers in the same cycle; contents change with the address
   function automatic logic [7:0] stk(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction
   always_comb stack_data = stk(stack_addr);

   // ************************************************************************
   // Shared tasks
   // ************************************************************************
   task automatic summarize();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (exp !== got) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Present one instruction; returns one step after the take edge, with outputs settled
   task automatic issue(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
      @(negedge clk_sys);
      valid  = 1'b1;
      opcode = op;
      opnd1  = b1;
      opnd2  = b2;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic idle();
      @(negedge clk_sys);
      valid = 1'b0;
   endtask

   // ************************************************************************
   // Scenarios
   // ************************************************************************
   task automatic t_operands();
      logic [7:0] a [4] = '{8'h00, 8'hFF, 8'h80, 8'h7F};
      for (int i = 0; i < 4; i++) begin
         next_pc = 16'h1000;
         issue(8'hE2, a[i], ~a[i]);
         chk("bit_sel", {13'h0000, a[i][6:4]}, {13'h0000, bit_sel});
         chk("polarity", {15'h0000, a[i][7]}, {15'h0000, polarity});
         chk("direct", {a[i], ~a[i]}, direct_addr);
         chk("ext_reg", {4'h0, a[i][3:0], ~a[i]}, {4'h0, ext_reg});
         chk("imm", {8'h00, ~a[i]}, {8'h00, imm_data});
         chk("pair_even", 16'h0000, {15'h0000, reg_pair[0]});
         chk("pair", {8'h00, a[i] & 8'hFE}, {8'h00, reg_pair});
         chk("wpair_even", 16'h0000, {15'h0000, work_pair[0]});
         chk("wpair", {12'h000, a[i][7:5], 1'b0}, {12'h000, work_pair});
         chk("rel", 16'h1000 + {{8{a[i][7]}}, a[i]}, rel_target);
      end
      idle();
   endtask

   // Values 1 and 0 bracket the nonzero test; displacements span both extremes
   task automatic t_dec_branch();
      logic [7:0] v [3] = '{8'h01, 8'h05, 8'h00};
      logic [7:0] d [3] = '{8'h10, 8'h80, 8'h7F};
      for (int i = 0; i < 3; i++) begin
         wreg_value = v[i];
         next_pc    = 16'h0100;
         issue({4'(i + 3), 4'hA}, d[i], 8'h00);
         chk("wreg_we", 16'h0001, {15'h0000, wreg_we});
         chk("wreg_sel", 16'(i + 3), {12'h000, wreg_sel});
         chk("wreg_data", {8'h00, v[i] - 8'h01}, {8'h00, wreg_data});
         chk("dbr_load", {15'h0000, v[i] != 8'h01}, {15'h0000, pc_load});
         if (v[i] != 8'h01) begin
            chk("dbr_pc", 16'h0100 + {{8{d[i][7]}}, d[i]}, pc_value);
         end
      end
      idle();
      @(posedge clk_sys);
      #1;
      chk("we_pulse", 16'h0000, {15'h0000, wreg_we});
   endtask

   task automatic t_jump();
      logic [7:0] f [2] = '{8'h50, 8'hA0};
      logic       c, z, s, v, base;
      for (int k = 0; k < 2; k++) begin
         for (int cnd = 0; cnd < 16; cnd++) begin
            flags = f[k];
            c = f[k][cod_pkg::FL_C];
            z = f[k][cod_pkg::FL_Z];
            s = f[k][cod_pkg::FL_S];
            v = f[k][cod_pkg::FL_V];
            case (cnd % 8)
               0: base = 1'b0;
               1: base = s ^ v;
               2: base = z | (s ^ v);
               3: base = c | z;
               4: base = v;
               5: base = s;
               6: base = z;
               default: base = c;
            endcase
            issue({4'(cnd), 4'hD}, 8'hC3, 8'h3C);
            chk("jump_load", {15'h0000, base ^ (cnd >= 8)}, {15'h0000, pc_load});
            if (pc_load === 1'b1) begin
               chk("jump_pc", 16'hC33C, pc_value);
            end
         end
      end
      idle();
   endtask

   // Return pops flags, then two pc bytes; a request while busy must be ignored
   task automatic t_int_return();
      sp = 16'h01FF;
      issue(8'hBF, 8'h00, 8'h00);
      chk("busy", 16'h0001, {15'h0000, busy});
      chk("stk_rd", 16'h0001, {15'h0000, stack_rd});
      chk("addr_f", 16'h01FF, stack_addr);
      wreg_value = 8'h09;
      issue(8'h2A, 8'h04, 8'h00);
      chk("flags_we", 16'h0001, {15'h0000, flags_we});
      chk("flags", {8'h00, stk(16'h01FF)}, {8'h00, flags_data});
      chk("addr_hi", 16'h0200, stack_addr);
      chk("refused", 16'h0000, {15'h0000, wreg_we});
      idle();
      @(posedge clk_sys);
      #1;
      chk("addr_lo", 16'h0201, stack_addr);
      @(posedge clk_sys);
      #1;
      chk("ret_load", 16'h0001, {15'h0000, pc_load});
      chk("ret_pc", {stk(16'h0200), stk(16'h0201)}, pc_value);
      chk("sp_we", 16'h0001, {15'h0000, sp_we});
      chk("sp", 16'h0202, sp_data);
      chk("irq_early", 16'h0000, {15'h0000, irq_set});
      @(posedge clk_sys);
      #1;
      chk("irq_set", 16'h0001, {15'h0000, irq_set});
      chk("not_busy", 16'h0000, {15'h0000, busy});
   endtask

   task automatic t_illegal();
      logic [7:0] op [11] = '{8'h2F, 8'h3F, 8'h4F, 8'hC6, 8'hC9, 8'hD9, 8'hF8, 8'hF9,
                              8'h1F, 8'h8D, 8'hE4};
      for (int i = 0; i < 11; i++) begin
         issue(op[i], 8'h00, 8'h00);
         chk("illegal", {15'h0000, i < 8}, {15'h0000, illegal});
      end
      issue(8'hF9, 8'h00, 8'h00);
      idle();
      @(posedge clk_sys);
      #1;
      chk("ill_pulse", 16'h0000, {15'h0000, illegal});
   endtask

   // ************************************************************************
   // Clock, reset, run and timeout
   // ************************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Whole run needs well under 200 cycles; the ceiling leaves a wide margin
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         summarize();
      end
   end

   initial begin
      rst_n      = 1'b0;
      valid      = 1'b0;
      opcode     = 8'h0F;
      opnd1      = 8'h00;
      opnd2      = 8'h00;
      next_pc    = 16'h0000;
      wreg_value = 8'h00;
      flags      = 8'h00;
      sp         = 16'h0000;
      repeat (12) @(negedge clk_sys);
      rst_n = 1'b1;
      t_operands();
      t_dec_branch();
      t_jump();
      t_int_return();
      t_illegal();
      summarize();
   end
endmodule // cod_decode_tb
